// file: logic/esync_top.sv
// Summary of operation
// - Burst source gives a 1 us pulse after each group.
// - Group length is readings or sweep count.
// - Integration source pulses once per integration end.
// - Aperture source holds level while converter measures.
// - Aperture level includes autozero and autorange.
// - Request source pulses on each service request.
// - Pulse on every enabled event, request set.
// - Request bit stays until clear status command.
// - Subprogram completion sets status bit zero.
// - One-shot command gives exactly one pulse.
// - After one-shot the source returns to off.
// - Buffering holds busy-time trigger without overrun error.
// - Aperture level may run with high polarity.
// - Polarity bit selects low or high going.
// - Reading source pulses after each completed reading.
`timescale 1ns/100ps
`default_nettype none

module esync_top
  import esync_pkg::*;
(
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Converter event strobes and levels
  input  wire logic              reading_done,
  input  wire logic              integration_done,
  input  wire logic              measuring,
  input  wire logic              autozero_active,
  input  wire logic              autorange_active,
  input  wire logic              reading_busy,
  // Status events
  input  wire logic [STAT_W-1:0] status_event,
  input  wire logic              subprogram_done,
  // External trigger pin and trigger handling
  input  wire logic              ext_trigger_pin,
  output logic                   trigger_start,
  output logic                   trigger_overrun_error,
  // Sync output, request and interrupt
  output logic                   external_sync_output,
  output logic                   service_request,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    esync_src_t        src;
    logic              pol;
    logic              tbuf;
    logic              sweep;
    logic [CNT_W-1:0]  nrdg;
    logic [CNT_W-1:0]  nsweep;
    logic [CNT_W-1:0]  bcnt;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] rqmask;
    logic              req;
    logic [IRQ_W-1:0]  ists;
    logic [IRQ_W-1:0]  imask;
    logic              held;
    logic              trig_prev;
    logic              start;
    logic              ovr;
    logic              fire;
    logic              abort;
    logic              out;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } esync_top_st_t;

  esync_top_st_t s;
  esync_top_st_t next_s;

  logic              trig_lvl;
  logic              aperture_level_source_lvl;
  logic              raw;
  logic [CNT_W-1:0]  glen;
  logic [CNT_W-1:0]  bnext;
  logic [STAT_W-1:0] ev_all;
  logic              srq_evt;
  logic              burst_evt;
  logic              ovr_evt;
  logic              trig_edge;
  logic              fire;
  logic              abort;
  logic              setup;
  logic              wr;
  logic              clr;
  logic [2:0]        new_src;
  logic [IRQ_W-1:0]  w1c;
  logic [IRQ_W-1:0]  iset;
  logic [31:0]       rd_word;
  logic              unmapped;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  esync_pulse_if pif ();

  assign pif.fire  = s.fire;
  assign pif.abort = s.abort;

  esync_pulse u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pif)
  );

  esync_sync3 u_trig_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_trigger_pin),
    .level   (trig_lvl)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s    = s;
    setup     = psel & ~penable;
    wr        = psel & penable & s.pready & pwrite;
    clr       = 1'b0;
    w1c       = '0;
    fire      = 1'b0;
    abort     = 1'b0;
    burst_evt = 1'b0;
    ovr_evt   = 1'b0;
    new_src   = pwdata[CTRL_SRC_LSB +: 3];
    rd_word   = '0;
    unmapped  = 1'b0;

    // Converter measuring, including autozero and autorange phases.
    aperture_level_source_lvl = measuring | autozero_active | autorange_active;

    // Burst grouping; a zero length is taken as one reading.
    glen = s.sweep ? s.nsweep : s.nrdg;
    if (glen == '0)
      glen = 16'h0001;
    bnext = s.bcnt + 16'h0001;
    if (reading_done)
    begin
      if (bnext >= glen)
      begin
        next_s.bcnt = '0;
        burst_evt   = 1'b1;
      end
      else
        next_s.bcnt = bnext;
    end

    // Status events and the request bit.
    ev_all = status_event;
    if (subprogram_done)
      ev_all[STAT_SUBPROG] = 1'b1;
    srq_evt = |(ev_all & s.rqmask);

    if (wr)
    begin
      unique case (paddr)
        OFF_CTRL:
        begin
          next_s.pol   = pwdata[CTRL_POL_BIT];
          next_s.tbuf  = pwdata[CTRL_TBUF_BIT];
          next_s.sweep = pwdata[CTRL_SWEEP_BIT];
          abort        = 1'b1;
          if (new_src == SRC_ONCE)
          begin
            fire       = 1'b1;
            next_s.src = SRC_OFF;
          end
          else if (new_src > SRC_ONCE)
            next_s.src = SRC_OFF;
          else
            next_s.src = esync_src_t'(new_src);
        end
        OFF_NRDG:
          next_s.nrdg = pwdata[CNT_W-1:0];
        OFF_NSWEEP:
          next_s.nsweep = pwdata[CNT_W-1:0];
        OFF_RQMASK:
          next_s.rqmask = pwdata[STAT_W-1:0];
        OFF_CMD:
          clr = pwdata[CMD_CLEAR_BIT];
        OFF_ISTAT:
          w1c = pwdata[IRQ_W-1:0];
        OFF_IMASK:
          next_s.imask = pwdata[IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end

    // A clear in the same cycle as a new event keeps the event.
    if (clr)
    begin
      next_s.stat = '0;
      next_s.req  = 1'b0;
    end
    next_s.stat = next_s.stat | ev_all;
    if (srq_evt)
      next_s.req = 1'b1;

    // Event selection: only the chosen source can fire.
    unique case (s.src)
      SRC_READING: fire = fire | reading_done;
      SRC_BURST:   fire = fire | burst_evt;
      SRC_INTEG:   fire = fire | integration_done;
      SRC_SRQ:     fire = fire | srq_evt;
      SRC_OFF,
      SRC_APERTURE_LEVEL_SOURCE,
      SRC_ONCE:    fire = fire;
      default:     fire = fire;
    endcase
    next_s.fire  = fire;
    next_s.abort = abort;

    // External trigger: held once while busy when buffering is on.
    trig_edge        = trig_lvl & ~s.trig_prev;
    next_s.trig_prev = trig_lvl;
    next_s.start     = 1'b0;
    if (s.held && !reading_busy)
    begin
      next_s.start = 1'b1;
      next_s.held  = 1'b0;
    end
    if (trig_edge)
    begin
      if (!reading_busy && !s.held)
        next_s.start = 1'b1;
      else if (s.tbuf && (!s.held || !reading_busy))
        next_s.held = 1'b1;
      else
        ovr_evt = 1'b1;
    end
    next_s.ovr = ovr_evt;

    // The aperture level bypasses the pulse counter; with the
    // source off only a one-shot pulse runs the counter, else the pin rests inactive.
    if (s.src == SRC_APERTURE_LEVEL_SOURCE)
      raw = aperture_level_source_lvl;
    else
      raw = pif.busy;
    next_s.out = raw ^ s.pol;

    // Interrupt status, write one to clear, set wins.
    iset              = '0;
    iset[IRQ_PULSE]   = s.fire;
    iset[IRQ_BURST]   = burst_evt;
    iset[IRQ_OVERRUN] = ovr_evt;
    iset[IRQ_SRQ]     = srq_evt;
    next_s.ists = (s.ists & ~w1c) | iset;
    next_s.irq  = |(next_s.ists & next_s.imask);

    // Read data is captured in the setup cycle.
    unique case (paddr)
      OFF_CTRL:
      begin
        rd_word[CTRL_SRC_LSB +: 3]  = s.src;
        rd_word[CTRL_POL_BIT]       = s.pol;
        rd_word[CTRL_TBUF_BIT]      = s.tbuf;
        rd_word[CTRL_SWEEP_BIT]     = s.sweep;
      end
      OFF_NRDG:   rd_word[CNT_W-1:0]  = s.nrdg;
      OFF_NSWEEP: rd_word[CNT_W-1:0]  = s.nsweep;
      OFF_EVSTAT:
      begin
        rd_word[STAT_W-1:0]    = s.stat;
        rd_word[EVSTAT_REQ_BIT] = s.req;
      end
      OFF_RQMASK: rd_word[STAT_W-1:0] = s.rqmask;
      OFF_CMD:    rd_word = '0;
      OFF_ISTAT:  rd_word[IRQ_W-1:0]  = s.ists;
      OFF_IMASK:  rd_word[IRQ_W-1:0]  = s.imask;
      OFF_LIVE:
      begin
        rd_word[LIVE_OUT_BIT]  = s.out;
        rd_word[LIVE_APERTURE_LEVEL_SOURCE_BIT] = aperture_level_source_lvl;
        rd_word[LIVE_HELD_BIT] = s.held;
        rd_word[LIVE_BUSY_BIT] = pif.busy;
        rd_word[LIVE_BCNT_LSB +: CNT_W] = s.bcnt;
      end
      default:    unmapped = 1'b1;
    endcase

    // Zero wait states: ready rises for the first access cycle.
    next_s.pready  = setup;
    next_s.pslverr = setup & unmapped;
    if (setup)
      next_s.prdata = rd_word;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s        <= '0;
      s.src    <= SRC_OFF;
      s.nrdg   <= NRDG_RST;
      s.nsweep <= NSWEEP_RST;
      s.rqmask <= RQMASK_RST;
      s.imask  <= IMASK_RST;
    end
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign trigger_start         = s.start;
  assign trigger_overrun_error = s.ovr;
  assign external_sync_output  = s.out;
  assign service_request       = s.req;
  assign irq                   = s.irq;

endmodule

`default_nettype wire

// file: inc/esync_pkg.sv
`default_nettype none

package esync_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned PULSE_WIDTH_NS = 1000;
  localparam int unsigned PULSE_CYCLES   =
    (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PW_W           = 8;
  localparam logic [PW_W-1:0] PULSE_LOAD = PW_W'(PULSE_CYCLES);

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int unsigned    ADDR_W     = 8;
  localparam logic [7:0]     OFF_CTRL   = 8'h00;
  localparam logic [7:0]     OFF_NRDG   = 8'h04;
  localparam logic [7:0]     OFF_NSWEEP = 8'h08;
  localparam logic [7:0]     OFF_EVSTAT = 8'h0c;
  localparam logic [7:0]     OFF_RQMASK = 8'h10;
  localparam logic [7:0]     OFF_CMD    = 8'h14;
  localparam logic [7:0]     OFF_ISTAT  = 8'h18;
  localparam logic [7:0]     OFF_IMASK  = 8'h1c;
  localparam logic [7:0]     OFF_LIVE   = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_SRC_LSB   = 0;
  localparam int unsigned CTRL_POL_BIT   = 3;
  localparam int unsigned CTRL_TBUF_BIT  = 4;
  localparam int unsigned CTRL_SWEEP_BIT = 5;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned STAT_W         = 8;
  localparam int unsigned STAT_SUBPROG   = 0;
  localparam int unsigned EVSTAT_REQ_BIT = 8;
  localparam int unsigned CMD_CLEAR_BIT  = 0;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_PULSE      = 0;
  localparam int unsigned IRQ_BURST      = 1;
  localparam int unsigned IRQ_OVERRUN    = 2;
  localparam int unsigned IRQ_SRQ        = 3;
  localparam int unsigned LIVE_OUT_BIT   = 0;
  localparam int unsigned LIVE_APERTURE_LEVEL_SOURCE_BIT  = 1;
  localparam int unsigned LIVE_HELD_BIT  = 2;
  localparam int unsigned LIVE_BUSY_BIT  = 3;
  localparam int unsigned LIVE_BCNT_LSB  = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0]  NRDG_RST   = 16'h0001;
  localparam logic [CNT_W-1:0]  NSWEEP_RST = 16'h0001;
  localparam logic [STAT_W-1:0] RQMASK_RST = 8'h00;
  localparam logic [IRQ_W-1:0]  IMASK_RST  = 4'h0;

  // ---------------------------------------------------------------
  // Event source selection
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_OFF,
    SRC_READING,
    SRC_BURST,
    SRC_INTEG,
    SRC_APERTURE_LEVEL_SOURCE,
    SRC_SRQ,
    SRC_ONCE
  } esync_src_t;

endpackage

`default_nettype wire

// file: inc/esync_pulse_if.sv
`timescale 1ns/100ps
`default_nettype none

interface esync_pulse_if;
  logic fire;
  logic abort;
  logic busy;

  modport gen (input fire, input abort, output busy);
  modport ctl (output fire, output abort, input busy);
endinterface

`default_nettype wire

// file: logic/esync_pulse.sv
`timescale 1ns/100ps
`default_nettype none

module esync_pulse
  import esync_pkg::*;
(
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Pulse request and state
  esync_pulse_if.gen  pif
);

  typedef struct packed {
    logic [PW_W-1:0] cnt;
    logic            busy;
  } esync_pulse_st_t;

  esync_pulse_st_t s;
  esync_pulse_st_t next_s;

  // A new request restarts the full width, so a retrigger never
  // shortens the pulse on the pin.
  always_comb
  begin
    next_s = s;
    if (pif.fire)
      next_s.cnt = PULSE_LOAD;
    else if (pif.abort)
      next_s.cnt = '0;
    else if (s.cnt != '0)
      next_s.cnt = s.cnt - 1'b1;
    next_s.busy = (next_s.cnt != '0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign pif.busy = s.busy;

endmodule

`default_nettype wire

// file: logic/esync_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module esync_sync3
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin in, clean level out
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } esync_sync_st_t;

  esync_sync_st_t s;
  esync_sync_st_t next_s;

  // The level only follows once two late stages agree, which also
  // rejects a single-cycle glitch on the pin.
  always_comb
  begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
      next_s.lvl = s.s3;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign level = s.lvl;

endmodule

`default_nettype wire

// file: bench/esync_scanner.sv
`timescale 1ns/100ps
`default_nettype none

module esync_scanner
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Sync pulse in, polarity and extra closure request
  input  wire logic       sync_pin,
  input  wire logic       low_going,
  input  wire logic       kick,
  input  wire logic [7:0] gap,
  // Channel-closed pulse back to the trigger pin
  output logic            trig_pin
);
  logic act;
  logic act_q;
  int   cnt;

  assign act = sync_pin ^ low_going;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      act_q    <= 1'b0;
      cnt      <= 0;
      trig_pin <= 1'b0;
    end
    else
    begin
      act_q <= act;
      // The relay moves once the sync pulse has ended, or on a kick, after the same gap;
      // the gap models a slow relay.
      if ((act_q && !act) || kick)
        cnt <= int'(gap) + 8;
      else if (cnt > 0)
        cnt <= cnt - 1;
      trig_pin <= (cnt > 0 && cnt <= 8);
    end
endmodule

`default_nettype wire

// file: bench/esync_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module esync_checker
  import esync_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  // Events and outputs
  input  wire logic [STAT_W-1:0] status_event,
  input  wire logic              subprogram_done,
  input  wire logic              trigger_start,
  input  wire logic              trigger_overrun_error,
  input  wire logic              service_request
);
  logic clr;

  assign clr = psel && penable && pwrite && paddr == OFF_CMD
               && pwdata[CMD_CLEAR_BIT];

  default clocking dck @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready outside access");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single)
    else $error("ready longer than one cycle");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  property p_err_data_zero;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data_zero: assert property (p_err_data_zero)
    else $error("refused read returns data");
  property p_start_single;
    trigger_start |=> !trigger_start;
  endproperty
  a_start_single: assert property (p_start_single)
    else $error("start longer than one cycle");
  property p_over_single;
    trigger_overrun_error |=> !trigger_overrun_error;
  endproperty
  a_over_single: assert property (p_over_single)
    else $error("overrun longer than one cycle");
  property p_srq_sticky;
    service_request && !clr |=> service_request;
  endproperty
  a_srq_sticky: assert property (p_srq_sticky)
    else $error("request dropped without clear");
  property p_srq_clear;
    clr && pready && status_event == '0 && !subprogram_done
      |=> !service_request;
  endproperty
  a_srq_clear: assert property (p_srq_clear)
    else $error("request survived clear");

  c_overrun: cover property (trigger_overrun_error);
  c_start: cover property (trigger_start);
  c_srq_drop: cover property (service_request ##1 !service_request);
  c_refused: cover property (pslverr);
endmodule

bind esync_top esync_checker chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_event(status_event), .subprogram_done(subprogram_done),
  .trigger_start(trigger_start),
  .trigger_overrun_error(trigger_overrun_error),
  .service_request(service_request));

`default_nettype wire

// file: bench/test_external_sync_pulse_output.sv
`timescale 1ns/100ps
`default_nettype none

module test_external_sync_pulse_output;
  import esync_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [10:0] ev = 11'h000;
  logic [2:0]  lvl = 3'h0;
  logic        busy = 1'b0;
  logic        kick = 1'b0;
  logic        pol = 1'b0;
  logic [7:0]  gap = 8'h00;
  logic [31:0] prdata;
  logic        pready, pslverr, tstart, tover, sync, srq, irq, trig;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_start = 0;
  int          n_over = 0;

  esync_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reading_done(ev[0]), .integration_done(ev[1]), .measuring(lvl[0]),
    .autozero_active(lvl[1]), .autorange_active(lvl[2]),
    .reading_busy(busy), .status_event(ev[10:3]),
    .subprogram_done(ev[2]), .ext_trigger_pin(trig),
    .trigger_start(tstart), .trigger_overrun_error(tover),
    .external_sync_output(sync), .service_request(srq), .irq(irq));
  esync_scanner scan_u (.pclk(pclk), .presetn(presetn), .sync_pin(sync),
    .low_going(pol), .kick(kick), .gap(gap), .trig_pin(trig));

  initial
    forever #2.5 pclk = ~pclk;

  always @(posedge pclk) n_start <= n_start + int'(tstart === 1'b1);
  always @(posedge pclk) n_over <= n_over + int'(tover === 1'b1);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] seen, x);
    samples_checked++;
    if (seen !== x)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, x, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, error and read data are all taken at the edge that sees
    // ready high; only the watchdog ends a wait that never ends.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    logic [32:0] q;
    apb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, x);
  endtask

  task automatic fire(input logic [10:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 11'h000;
  endtask

  task automatic pulse(input int lat);
    int k;
    int w;
    k = 0;
    w = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end
    while (k < 12 && sync !== ~pol);
    while (w < 400 && sync === ~pol)
    begin
      @(negedge pclk);
      w++;
    end
    chk("latency", k, lat);
    chk("width", w, PULSE_CYCLES);
    @(posedge pclk);
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(negedge pclk);
      seen |= (sync !== pol);
    end
    chk("idle", seen, 1'b0);
    @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    int g;
    int h;
    int s0;
    int s1;
    void'($urandom(28219));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 33'h0);
    rd(OFF_NRDG, {17'h0, NRDG_RST});
    rd(OFF_NSWEEP, {17'h0, NSWEEP_RST});
    rd(OFF_RQMASK, {25'h0, RQMASK_RST});
    rd(OFF_IMASK, {29'h0, IMASK_RST});
    rd(8'h24, {1'b1, 32'h0});
    $display("test registers done");
    g = 2 + $urandom % 4;
    h = 2 + $urandom % 4;
    gap <= 8'($urandom % 16);
    wr(OFF_NRDG, 32'(g));
    wr(OFF_CTRL, 32'h2);
    repeat (g - 1) fire(11'h001);
    quiet(8);
    fire(11'h001);
    pulse(3);
    wr(OFF_NSWEEP, 32'(h));
    wr(OFF_CTRL, 32'h22);
    repeat (h - 1) fire(11'h001);
    quiet(8);
    fire(11'h001);
    pulse(3);
    $display("test burst done");
    for (int p = 0; p < 2; p++)
    begin
      wr(OFF_CTRL, 32'(p * 8 + 1));
      pol <= p[0];
      repeat (48) @(posedge pclk);
      s0 = n_start;
      fire(11'h002);
      quiet(8);
      fire(11'h001);
      pulse(3);
      repeat (48) @(posedge pclk);
      chk("scanner start", 33'(n_start - s0), 33'h1);
    end
    wr(OFF_CTRL, 32'h3);
    pol <= 1'b0;
    repeat (48) @(posedge pclk);
    fire(11'h002);
    pulse(3);
    fire(11'h001);
    quiet(8);
    wr(OFF_CTRL, 32'h0);
    fire(11'h7fb);
    quiet(8);
    $display("test event sources done");
    wr(OFF_CTRL, 32'h4);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      lvl <= 3'(1 << i);
      repeat (3) @(negedge pclk);
      chk("aperture", sync, 33'h1);
      @(posedge pclk);
      lvl <= 3'h0;
      repeat (3) @(negedge pclk);
      chk("aperture", sync, 33'h0);
    end
    $display("test aperture done");
    // Earlier status strobes are still latched; start from a clean set.
    wr(OFF_CMD, 32'h1);
    chk("request", srq, 33'h0);
    wr(OFF_RQMASK, 32'h1);
    wr(OFF_CTRL, 32'h5);
    fire(11'h004);
    pulse(3);
    rd(OFF_EVSTAT, 33'h101);
    chk("request", srq, 33'h1);
    g = $urandom % 256;
    fire({8'(g) | 8'h01, 3'h0});
    pulse(3);
    rd(OFF_EVSTAT, 33'(32'h101 | g));
    fire(11'h010);
    quiet(8);
    wr(OFF_CMD, 32'h1);
    rd(OFF_EVSTAT, 33'h0);
    chk("request", srq, 33'h0);
    $display("test request done");
    wr(OFF_IMASK, 32'h0);
    wr(OFF_ISTAT, 32'hf);
    rd(OFF_ISTAT, 33'h0);
    wr(OFF_CTRL, 32'h6);
    pulse(3);
    rd(OFF_CTRL, 33'h0);
    fire(11'h002);
    quiet(8);
    rd(OFF_ISTAT, 33'h1);
    @(negedge pclk);
    chk("irq masked", irq, 33'h0);
    wr(OFF_IMASK, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq", irq, 33'h1);
    wr(OFF_ISTAT, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq cleared", irq, 33'h0);
    $display("test one-shot and interrupt done");
    repeat (60) @(posedge pclk);
    for (int b = 1; b >= 0; b--)
    begin
      wr(OFF_CTRL, 32'(b * 16));
      s0 = n_start;
      s1 = n_over;
      @(posedge pclk);
      busy <= 1'b1;
      @(posedge pclk);
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      repeat (40) @(posedge pclk);
      busy <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("overrun", 33'(n_over - s1), 33'(1 - b));
      chk("start", 33'(n_start - s0), 33'(b));
    end
    $display("test trigger done");
    tally_and_finish;
  end

  initial
  begin
    // The sequence needs well under ten thousand cycles.
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
